/* File: verilog/dpgpio_top.sv */
// Dual port GPIO with port change and external interrupt flags.
// Assumes a classic Wishbone master and external pins in another domain.
//
// Overview of operation
// - Port A is six bidirectional pins, each with direction bit and latch.
// - Direction one tristates the pin; zero drives it from the latch.
// - Port data reads return pin levels; writes update the output latch.
// - A port write with byte lane 0 stores the data; without it, it stores the pins into the latch.
// - Port A bit 4 feeds counter clock input and drives low only.
// - Analog select field chooses digital or analog use of shared pins.
// - After reset shared pins are analog and read back as zero.
// - Direction bits still drive pins in analog mode; software keeps them input.
// - Unimplemented bits of port A, direction A and analog config read zero.
// - Port B is eight bidirectional pins with the same direction behaviour.
// - Option bit 7 low enables weak pull-ups on all port B input pins.
// - Pull-up is off on any port B pin set as output.
// - Reset leaves all port B pull-ups disabled.
// - Only upper four port B input pins take part in change detection.
// - Inputs compare to value latched on last port B access; any mismatch sets change flag bit 0.
// - Mismatch keeps setting flag; port B access ends it so clear works.
// - Port change interrupt condition can wake the device from sleep.
// - Port B bit 0 is external interrupt input; option bit 6 selects edge.
`include "dpgpio_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module dpgpio_top #(
	parameter int WB_ADR_W = 12
) (
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [WB_ADR_W-1:0] i_wb_adr,
	input wire logic [31:0] i_wb_dat,
	input wire logic [3:0] i_wb_sel,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	input wire dpgpio_pkg::dpgpio_port_a_t i_port_a_pins,
	output dpgpio_pkg::dpgpio_port_a_t o_port_a_out,
	output dpgpio_pkg::dpgpio_port_a_t o_port_a_oe,
	output dpgpio_pkg::dpgpio_port_a_t o_analog_mask,
	output logic o_counter_clock_in,
	input wire dpgpio_pkg::dpgpio_byte_t i_port_b_pins,
	output dpgpio_pkg::dpgpio_byte_t o_port_b_out,
	output dpgpio_pkg::dpgpio_byte_t o_port_b_oe,
	output dpgpio_pkg::dpgpio_byte_t o_port_b_pullup,
	output logic o_port_change_flag,
	output logic o_ext_irq_flag,
	output logic o_wake
);
	import dpgpio_pkg::*;

	if (WB_ADR_W < 11) begin : g_bad_adr
		$error("WB_ADR_W must be at least 11");
	end

	localparam dpgpio_state_s RST = '{
		port_a_direction: `DPGPIO_RST_DIR_A,
		analog_select_field: `DPGPIO_RST_ANA_CFG,
		port_b_direction: `DPGPIO_RST_DIR_B,
		option_reg: `DPGPIO_RST_OPTION,
		oe_a: 6'h00,
		analog_mask: 6'h2F,
		default: '0
	};

	dpgpio_state_s s;
	dpgpio_state_s next_s;

	logic req;
	logic wr;
	logic hit;
	logic lane;
	logic [7:0] idx;
	logic [7:0] wd;
	logic [5:0] an_mask;
	logic [5:0] pins_a;
	logic mismatch;
	logic edge_seen;

	// Analog pin map per select field; bit 4 is always digital
	function automatic logic [5:0] ana_map(input logic [2:0] f);
		logic [5:0] m;
		m = 6'h00;
		case (f)
			3'h4: m = 6'h0B;
			3'h5: m = 6'h0B;
			3'h6: m = 6'h00;
			3'h7: m = 6'h00;
			default: m = 6'h2F;
		endcase
		return m;
	endfunction

	always_comb begin
		next_s = s;
		idx = i_wb_adr[9:2];
		hit = (i_wb_adr[WB_ADR_W-1:10] == '0);
		req = i_wb_cyc & i_wb_stb & ~s.ack;
		wr = req & i_wb_we & hit;
		lane = i_wb_sel[0];
		wd = i_wb_dat[7:0];
		an_mask = ana_map(s.analog_select_field);
		pins_a = s.sa2 & ~an_mask;
		mismatch = |((s.sb2[7:4] ^ s.ref_b) & s.port_b_direction[7:4]);
		edge_seen = s.warm[2] & (s.option_reg[`DPGPIO_OPT_EDGE] ?
			(s.sb2[0] & ~s.irq_pin_d) : (~s.sb2[0] & s.irq_pin_d));

		// Two-flop synchronisers for pins
		next_s.sa1 = i_port_a_pins;
		next_s.sa2 = s.sa1;
		next_s.sb1 = i_port_b_pins;
		next_s.sb2 = s.sb1;
		next_s.irq_pin_d = s.sb2[0];
		// Edge detector stays quiet until its delay stage holds a real pin level
		next_s.warm = {s.warm[1:0], 1'b1};

		// Bus answer one cycle after the request
		next_s.ack = req;
		if (req && !i_wb_we) begin
			next_s.rdat = 8'h00;
			if (hit) begin
				case (idx)
					`DPGPIO_IDX_PORT_A: next_s.rdat = {2'b00, pins_a};
					`DPGPIO_IDX_PORT_B: next_s.rdat = s.sb2;
					`DPGPIO_IDX_DIR_A: next_s.rdat = {2'b00, s.port_a_direction};
					`DPGPIO_IDX_DIR_B: next_s.rdat = s.port_b_direction;
					`DPGPIO_IDX_ANA_CFG: next_s.rdat = {5'h00, s.analog_select_field};
					`DPGPIO_IDX_OPTION: next_s.rdat = s.option_reg;
					`DPGPIO_IDX_INT_CTRL: next_s.rdat = {4'h0, s.change_irq_en, 1'b0,
						s.ext_irq_flag, s.port_change_flag};
					default: next_s.rdat = 8'h00;
				endcase
			end
		end

		// Register writes; an absent lane writes back the pins to a port latch and leaves other registers unchanged
		if (wr) begin
			case (idx)
				`DPGPIO_IDX_PORT_A: next_s.lat_a = lane ? wd[5:0] : pins_a;
				`DPGPIO_IDX_PORT_B: next_s.lat_b = lane ? wd : s.sb2;
				`DPGPIO_IDX_DIR_A: begin
					if (lane) begin
						next_s.port_a_direction = wd[5:0];
					end
				end
				`DPGPIO_IDX_DIR_B: begin
					if (lane) begin
						next_s.port_b_direction = wd;
					end
				end
				`DPGPIO_IDX_ANA_CFG: begin
					if (lane) begin
						next_s.analog_select_field = wd[2:0];
					end
				end
				`DPGPIO_IDX_OPTION: begin
					if (lane) begin
						next_s.option_reg = wd;
					end
				end
				`DPGPIO_IDX_INT_CTRL: begin
					if (lane) begin
						next_s.port_change_flag = wd[`DPGPIO_IC_CHANGE];
						next_s.ext_irq_flag = wd[`DPGPIO_IC_EXT];
						next_s.change_irq_en = wd[`DPGPIO_IC_CHANGE_EN];
					end
				end
				default: begin
				end
			endcase
		end

		// Any port B access re-latches the change reference
		if (req && hit && idx == `DPGPIO_IDX_PORT_B) begin
			next_s.ref_b = s.sb2[7:4];
		end

		// Hardware sets win over software clears
		if (mismatch) begin
			next_s.port_change_flag = 1'b1;
		end
		if (edge_seen) begin
			next_s.ext_irq_flag = 1'b1;
		end

		// Registered pin drive
		next_s.oe_a = ~s.port_a_direction;
		next_s.out_a = s.lat_a;
		next_s.out_a[`DPGPIO_A_OPEN_DRAIN] = 1'b0;
		next_s.oe_a[`DPGPIO_A_OPEN_DRAIN] = ~s.port_a_direction[`DPGPIO_A_OPEN_DRAIN] &
			~s.lat_a[`DPGPIO_A_OPEN_DRAIN];
		next_s.counter_clock_in = s.sa2[`DPGPIO_A_OPEN_DRAIN];
		next_s.analog_mask = an_mask;
		next_s.oe_b = ~s.port_b_direction;
		next_s.out_b = s.lat_b;
		next_s.pullup_b = {8{~s.option_reg[`DPGPIO_OPT_PULLUP_N]}} & s.port_b_direction;
		next_s.wake = s.port_change_flag & s.change_irq_en;
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s <= RST;
		end else begin
			s <= next_s;
		end
	end

	assign o_wb_dat = {24'h000000, s.rdat};
	assign o_wb_ack = s.ack;
	assign o_port_a_out = s.out_a;
	assign o_port_a_oe = s.oe_a;
	assign o_analog_mask = s.analog_mask;
	assign o_counter_clock_in = s.counter_clock_in;
	assign o_port_b_out = s.out_b;
	assign o_port_b_oe = s.oe_b;
	assign o_port_b_pullup = s.pullup_b;
	assign o_port_change_flag = s.port_change_flag;
	assign o_ext_irq_flag = s.ext_irq_flag;
	assign o_wake = s.wake;

	// Checks
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_reset_n);

	sequence s_wr_dir_a;
		wr && lane && idx == `DPGPIO_IDX_DIR_A;
	endsequence

	sequence s_rd_port(logic [7:0] r);
		req && hit && !i_wb_we && idx == r;
	endsequence

	sequence s_wr_a_nolane;
		wr && !lane && idx == `DPGPIO_IDX_PORT_A;
	endsequence

	sequence s_wr_ic(logic v);
		wr && lane && idx == `DPGPIO_IDX_INT_CTRL && i_wb_dat[`DPGPIO_IC_CHANGE] == v;
	endsequence

	sequence s_wr_port_b;
		wr && idx == `DPGPIO_IDX_PORT_B;
	endsequence

	a_dir_a_drive: assert property (
		s_wr_dir_a |-> ##2 (o_port_a_oe[3:0] == ~$past(i_wb_dat[3:0], 2)))
		else $error("port A enable does not follow direction write");

	a_bit4_low_only: assert property (
		o_port_a_oe[4] |-> !$past(s.lat_a[4]) && !$past(s.port_a_direction[4]))
		else $error("open drain pin enabled while latch high");

	a_bit4_out_zero: assert property (
		o_port_a_out[4] == 1'b0)
		else $error("open drain pin drives high");

	a_analog_reads_zero: assert property (
		s_rd_port(`DPGPIO_IDX_PORT_A) |=> ((o_wb_dat[7:0] & {2'b11, $past(an_mask)}) == 8'h00))
		else $error("analog pin read back nonzero");

	a_port_b_pins: assert property (
		s_rd_port(`DPGPIO_IDX_PORT_B) |=> o_wb_ack && o_wb_dat[7:0] == $past(s.sb2))
		else $error("port B read does not return pins");

	a_rmw_no_lane: assert property (
		s_wr_a_nolane |=> s.lat_a == $past(pins_a))
		else $error("write without lane did not store pins");

	a_pullup_output: assert property (
		(o_port_b_pullup & o_port_b_oe) == 8'h00)
		else $error("pull-up on output pin");

	a_change_excluded: assert property (
		s.port_b_direction[7:4] == 4'h0 |-> !mismatch)
		else $error("output pin takes part in change");

	a_change_sets: assert property (
		mismatch |=> o_port_change_flag)
		else $error("mismatch did not set change flag");

	a_ref_relatch: assert property (
		s_rd_port(`DPGPIO_IDX_PORT_B) |=> s.ref_b == $past(s.sb2[7:4]))
		else $error("port B read did not relatch reference");

	a_wake_follows: assert property (
		(o_port_change_flag && s.change_irq_en) |=> o_wake)
		else $error("wake missing for change interrupt");

	a_ext_edge_flag: assert property (
		edge_seen |=> o_ext_irq_flag)
		else $error("external edge not flagged");

	a_bus_single_ack: assert property (
		req |=> o_wb_ack ##1 !o_wb_ack)
		else $error("ack not a single cycle");

	a_dir_b_drive: assert property (
		o_port_b_oe == ~$past(s.port_b_direction))
		else $error("port B enable does not follow direction");

	a_port_b_drive: assert property (
		o_port_b_out == $past(s.lat_b))
		else $error("port B output does not follow latch");

	a_port_a_drive: assert property (
		{o_port_a_out[5], o_port_a_out[3:0]} == {$past(s.lat_a[5]), $past(s.lat_a[3:0])})
		else $error("port A output does not follow latch");

	a_dir_a_hold: assert property (
		o_port_a_oe[3:0] == ~$past(s.port_a_direction[3:0]))
		else $error("port A enable ignores direction");

	a_cclk_follows: assert property (
		o_counter_clock_in == $past(s.sa2[`DPGPIO_A_OPEN_DRAIN]))
		else $error("counter clock input does not follow pin");

	a_mask_follows: assert property (
		o_analog_mask == $past(an_mask))
		else $error("analog mask does not follow select field");

	a_dir_a_upper_zero: assert property (
		s_rd_port(`DPGPIO_IDX_DIR_A) |=> o_wb_dat[7:6] == 2'b00)
		else $error("direction A upper bits read nonzero");

	a_cfg_upper_zero: assert property (
		s_rd_port(`DPGPIO_IDX_ANA_CFG) |=> o_wb_dat[7:3] == 5'h00)
		else $error("analog config upper bits read nonzero");

	a_pullup_enable: assert property (
		o_port_b_pullup == ($past(s.port_b_direction) & {8{~$past(s.option_reg[`DPGPIO_OPT_PULLUP_N])}}))
		else $error("pull-up does not follow enable bit");

	a_clear_blocked: assert property (
		s_wr_ic(1'b0) ##0 mismatch |=> o_port_change_flag)
		else $error("change flag cleared during mismatch");

	a_clear_takes: assert property (
		s_wr_ic(1'b0) ##0 !mismatch |=> !o_port_change_flag)
		else $error("change flag clear ignored");

	a_wake_off: assert property (
		!o_port_change_flag |=> !o_wake)
		else $error("wake without change flag");

	a_ext_stays: assert property (
		(!edge_seen && !o_ext_irq_flag && !wr) |=> !o_ext_irq_flag)
		else $error("external flag set without edge");

	a_edge_polarity: assert property (
		edge_seen |-> s.sb2[0] == s.option_reg[`DPGPIO_OPT_EDGE])
		else $error("external edge of wrong polarity");

	a_wr_b_relatch: assert property (
		s_wr_port_b |=> s.ref_b == $past(s.sb2[7:4]))
		else $error("port B write did not relatch reference");

	a_upper_dat_zero: assert property (
		o_wb_dat[31:8] == 24'h000000)
		else $error("read data upper bits nonzero");

	a_ack_needs_req: assert property (
		o_wb_ack |-> $past(req))
		else $error("ack without request");

	a_read_int_ctrl: assert property (
		s_rd_port(`DPGPIO_IDX_INT_CTRL) |=> o_wb_dat[0] == $past(s.port_change_flag))
		else $error("change flag read back wrong");

	a_unmapped_zero: assert property (
		(req && !hit && !i_wb_we) |=> o_wb_dat[7:0] == 8'h00)
		else $error("unmapped read nonzero");

	a_rmw_lane: assert property (
		(wr && lane && idx == `DPGPIO_IDX_PORT_A) |=> s.lat_a == $past(i_wb_dat[5:0]))
		else $error("port A write did not store data");
endmodule
`default_nettype wire

/* File: verilog/dpgpio_consts.svh */
// Constants for the dual port GPIO block: register indexes, field
// positions and reset values.
// Assumes inclusion by bare name from the top module and the testbench.
`ifndef DPGPIO_CONSTS_SVH
`define DPGPIO_CONSTS_SVH

// Register indexes; byte address is four times the index
`define DPGPIO_IDX_PORT_A 8'h05
`define DPGPIO_IDX_PORT_B 8'h06
`define DPGPIO_IDX_INT_CTRL 8'h0B
`define DPGPIO_IDX_OPTION 8'h81
`define DPGPIO_IDX_DIR_A 8'h85
`define DPGPIO_IDX_DIR_B 8'h86
`define DPGPIO_IDX_ANA_CFG 8'h9F

// Field positions
`define DPGPIO_OPT_PULLUP_N 7
`define DPGPIO_OPT_EDGE 6
`define DPGPIO_IC_CHANGE 0
`define DPGPIO_IC_EXT 1
`define DPGPIO_IC_CHANGE_EN 3
`define DPGPIO_A_OPEN_DRAIN 4

// Reset values
`define DPGPIO_RST_DIR_A 6'h3F
`define DPGPIO_RST_ANA_CFG 3'h0
`define DPGPIO_RST_DIR_B 8'hFF
`define DPGPIO_RST_OPTION 8'hFF

`endif

/* File: verilog/dpgpio_pkg.sv */
// Types shared by the dual port GPIO block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package dpgpio_pkg;
	typedef logic [7:0] dpgpio_byte_t;
	typedef logic [5:0] dpgpio_port_a_t;

	typedef struct packed {
		logic [5:0] port_a_direction;
		logic [5:0] lat_a;
		logic [2:0] analog_select_field;
		logic [7:0] port_b_direction;
		logic [7:0] lat_b;
		logic [7:0] option_reg;
		logic port_change_flag;
		logic ext_irq_flag;
		logic change_irq_en;
		logic [3:0] ref_b;
		logic [5:0] sa1;
		logic [5:0] sa2;
		logic [7:0] sb1;
		logic [7:0] sb2;
		logic irq_pin_d;
		logic ack;
		logic [7:0] rdat;
		logic [5:0] out_a;
		logic [5:0] oe_a;
		logic [7:0] out_b;
		logic [7:0] oe_b;
		logic [7:0] pullup_b;
		logic counter_clock_in;
		logic [5:0] analog_mask;
		logic wake;
		logic [2:0] warm;
	} dpgpio_state_s;
endpackage
`default_nettype wire

/* File: dv/dpgpio_board.sv */
// Board model: resolves each pin from the device drivers, external drivers and pull-ups.
// Assumes the bench sets external levels and enables off the clock edge.
`timescale 1ns/1ps
`default_nettype none
module dpgpio_board (
	input wire logic i_clk,
	input wire logic [5:0] i_a_out,
	input wire logic [5:0] i_a_oe,
	input wire logic [5:0] i_a_ext,
	input wire logic [5:0] i_a_ext_en,
	input wire logic [7:0] i_b_out,
	input wire logic [7:0] i_b_oe,
	input wire logic [7:0] i_b_pu,
	input wire logic [7:0] i_b_ext,
	input wire logic [7:0] i_b_ext_en,
	output logic [5:0] o_a_pins,
	output logic [7:0] o_b_pins
);
	logic flip = 1'b0;
	// Undriven lines without pull-up toggle every cycle
	always_ff @(posedge i_clk) begin
		flip <= ~flip;
	end
	always_comb begin
		for (int k = 0; k < 6; k++) begin
			o_a_pins[k] = i_a_oe[k] ? i_a_out[k] : i_a_ext_en[k] ? i_a_ext[k] : flip;
		end
		for (int k = 0; k < 8; k++) begin
			o_b_pins[k] = i_b_oe[k] ? i_b_out[k] : i_b_ext_en[k] ? i_b_ext[k] : i_b_pu[k] ? 1'b1 : flip;
		end
	end
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
// Testbench: drives the GPIO block over Wishbone and judges pins and flags.
// Assumes the board model resolves the pin levels.
`include "dpgpio_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import dpgpio_pkg::*;
	localparam logic [7:0] ix_pa = `DPGPIO_IDX_PORT_A;
	localparam logic [7:0] ix_pb = `DPGPIO_IDX_PORT_B;
	localparam logic [7:0] ix_ic = `DPGPIO_IDX_INT_CTRL;
	localparam logic [7:0] ix_op = `DPGPIO_IDX_OPTION;
	localparam logic [7:0] ix_da = `DPGPIO_IDX_DIR_A;
	localparam logic [7:0] ix_db = `DPGPIO_IDX_DIR_B;
	localparam logic [7:0] ix_an = `DPGPIO_IDX_ANA_CFG;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [11:0] adr = 12'h000;
	logic [31:0] wdat = 32'h00000000;
	logic [3:0] sel = 4'h0;
	logic [31:0] rdat;
	logic ack, cclk, pcf, eif, wake;
	dpgpio_port_a_t pa, a_out, a_oe, amask;
	dpgpio_port_a_t a_ext = 6'h3F;
	dpgpio_port_a_t a_en = 6'h3F;
	dpgpio_byte_t pb, b_out, b_oe, b_pu;
	dpgpio_byte_t b_ext = 8'h00;
	logic [7:0] q;
	int fail_count = 0;
	int tests_run = 0;
	always #12.5 clk = ~clk;
	dpgpio_top i_dpgpio_top (.i_core_clk(clk), .i_reset_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel), .o_wb_dat(rdat), .o_wb_ack(ack), .i_port_a_pins(pa),
		.o_port_a_out(a_out), .o_port_a_oe(a_oe), .o_analog_mask(amask), .o_counter_clock_in(cclk),
		.i_port_b_pins(pb), .o_port_b_out(b_out), .o_port_b_oe(b_oe), .o_port_b_pullup(b_pu),
		.o_port_change_flag(pcf), .o_ext_irq_flag(eif), .o_wake(wake));
	dpgpio_board i_dpgpio_board (.i_clk(clk), .i_a_out(a_out), .i_a_oe(a_oe), .i_a_ext(a_ext), .i_a_ext_en(a_en),
		.i_b_out(b_out), .i_b_oe(b_oe), .i_b_pu(b_pu), .i_b_ext(b_ext), .i_b_ext_en(8'hFF), .o_a_pins(pa),
		.o_b_pins(pb));
	task automatic end_sim();
		$display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask
	task automatic wb(input logic [7:0] ix, input logic w, input logic [7:0] d, input logic s);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {2'b00, ix, 2'b00};
		wdat <= {24'h000000, d};
		sel <= {3'b000, s};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rdat[7:0];
		if (n >= 50) chk("ack", 8'h01, 8'h00);
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] ix, input logic [7:0] d);
		wb(ix, 1'b1, d, 1'b1);
	endtask
	task automatic rd(input logic [7:0] ix, input logic [7:0] e, input string nm);
		wb(ix, 1'b0, 8'h00, 1'b1);
		chk(nm, e, q);
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic t_reset();
		chk("mask", 8'h2F, {2'b00, amask});
		chk("pullup", 8'h00, b_pu);
		chk("oe a", 8'h00, {2'b00, a_oe});
		wt(3);
		rd(ix_pa, 8'h10, "pa analog");
		wr(ix_an, 8'hFF);
		rd(ix_an, 8'h07, "ana cfg");
		wr(ix_da, 8'hFF);
		rd(ix_da, 8'h3F, "dir a");
	endtask
	task automatic t_analog();
		wr(ix_an, 8'h04);
		wt(3);
		chk("mask 100", 8'h0B, {2'b00, amask});
		rd(ix_pa, 8'h34, "pa 100");
		wr(ix_an, 8'h06);
		wt(3);
		chk("mask 110", 8'h00, {2'b00, amask});
	endtask
	task automatic t_port_a();
		a_en <= 6'h10;
		a_ext <= 6'h00;
		wr(ix_da, 8'h00);
		wr(ix_pa, 8'h3F);
		wt(3);
		chk("oe a", 8'h2F, {2'b00, a_oe});
		chk("out a", 8'h2F, {2'b00, a_out});
		rd(ix_pa, 8'h2F, "pa pins");
		a_ext <= 6'h10;
		wt(4);
		chk("cclk", 8'h01, {7'h00, cclk});
		wr(ix_pa, 8'h00);
		wt(4);
		chk("oe a low", 8'h3F, {2'b00, a_oe});
		chk("cclk low", 8'h00, {7'h00, cclk});
		rd(ix_pa, 8'h00, "pa low");
		wr(ix_da, 8'hFF);
	endtask
	task automatic t_port_b();
		b_ext <= 8'hA5;
		wt(4);
		wb(ix_pb, 1'b1, 8'h00, 1'b0);
		wr(ix_db, 8'h00);
		wt(3);
		chk("rmw", 8'hA5, b_out);
		chk("oe b", 8'hFF, b_oe);
		wr(ix_pb, 8'h3C);
		wt(2);
		rd(ix_pb, 8'h3C, "pb");
		wr(ix_db, 8'h0F);
		wr(ix_op, 8'h7F);
		wt(3);
		chk("pullup on", 8'h0F, b_pu);
		wr(ix_op, 8'hFF);
		wt(3);
		chk("pullup off", 8'h00, b_pu);
	endtask
	task automatic t_change();
		wr(ix_db, 8'hFF);
		b_ext <= 8'h00;
		wt(4);
		rd(ix_pb, 8'h00, "pb ref");
		wr(ix_ic, 8'h08);
		b_ext <= 8'h04;
		wt(5);
		rd(ix_ic, 8'h08, "low pin");
		b_ext <= 8'h24;
		wt(5);
		rd(ix_ic, 8'h09, "change");
		chk("wake", 8'h01, {7'h00, wake});
		chk("change flag", 8'h01, {7'h00, pcf});
		wr(ix_ic, 8'h08);
		rd(ix_ic, 8'h09, "still set");
		rd(ix_pb, 8'h24, "pb");
		wr(ix_ic, 8'h08);
		rd(ix_ic, 8'h08, "cleared");
		chk("flag off", 8'h00, {7'h00, pcf});
		chk("wake off", 8'h00, {7'h00, wake});
		wr(ix_pb, 8'h80);
		wr(ix_db, 8'h7F);
		wt(5);
		rd(ix_ic, 8'h08, "out pin");
		wr(ix_db, 8'hFF);
	endtask
	task automatic step(input logic v, input logic e);
		b_ext[0] <= v;
		wt(5);
		chk("ext flag", {7'h00, e}, {7'h00, eif});
		wr(ix_ic, 8'h00);
	endtask
	task automatic t_ext();
		wr(ix_op, 8'hFF);
		step(1'b1, 1'b1);
		step(1'b0, 1'b0);
		wr(ix_op, 8'hBF);
		step(1'b1, 1'b0);
		step(1'b0, 1'b1);
		wr(8'h10, 8'hFF);
		rd(8'h10, 8'h00, "unmapped");
	endtask
	task automatic t_midrst();
		wr(ix_op, 8'h7F);
		wt(3);
		chk("pullup all", 8'hFF, b_pu);
		rst_n <= 1'b0;
		wt(2);
		chk("mask rst", 8'h2F, {2'b00, amask});
		chk("pullup rst", 8'h00, b_pu);
		rst_n <= 1'b1;
		wt(3);
		rd(ix_an, 8'h00, "ana rst");
		rd(ix_pa, 8'h10, "pa rst");
		rd(ix_op, 8'hFF, "op rst");
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		end_sim();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_analog();
		t_port_a();
		t_port_b();
		t_change();
		t_ext();
		t_midrst();
		end_sim();
	end
endmodule
`default_nettype wire
